/* File: dv/dpwm_pad_model.sv */
`timescale 1ns/100ps
module dpwm_pad_model (
	input  wire logic clk_i,
	input  wire logic pad_i,
	input  wire logic pad_oe_n_i,
	output logic      line_o
);
	logic last_reg;
	always_ff @(posedge clk_i) begin
		if (!pad_oe_n_i) begin
			last_reg <= pad_i;
		end
	end
	// The pad has no pull, so a released line shows the inverse of what was last driven.
	assign line_o = pad_oe_n_i ? ~last_reg : pad_i;
endmodule : dpwm_pad_model

/* File: dv/dpwm_top_chk.sv */
`timescale 1ns/100ps
module dpwm_top_chk (
	input wire logic        CORE_CLK_I,
	input wire logic        RST_I,
	input wire logic [4:0]  ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic        WR_I,
	input wire logic        RD_I,
	input wire logic [31:0] RDATA_O,
	input wire logic        CHAN_ONE_PAD_O,
	input wire logic        CHAN_ONE_PAD_OE_N_O,
	input wire logic        CHAN_TWO_PAD_O,
	input wire logic        CHAN_TWO_PAD_OE_N_O
);
	logic [31:0] ctl;
	logic [2:0]  age;
	// Mode checks wait until the control value has had time to reach the pads.
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctl <= '0;
			age <= '0;
		end else if (WR_I && ADDR_I == 5'h08) begin
			ctl <= WDATA_I;
			age <= '0;
		end else if (age != 3'h7) begin
			age <= age + 3'h1;
		end
	end
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_write;
		WR_I && ADDR_I[1:0] == 2'h0 && ADDR_I != 5'h1c;
	endsequence
	sequence s_read_back;
		RD_I && !WR_I && ADDR_I == $past(ADDR_I);
	endsequence
	a_write_readback: assert property (s_write ##1 s_read_back |=> RDATA_O == $past(WDATA_I, 2))
		else $error("read back differs from write");
	a_idle_zero: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
		else $error("read data not zero when idle");
	a_blink_reserved: assert property ($past(RD_I) && $past(ADDR_I) == 5'h1c |-> RDATA_O[31:10] == 22'h0)
		else $error("reserved blink bits set");
	a_misaligned_zero: assert property ($past(RD_I) && $past(ADDR_I[1:0]) != 2'h0 |-> RDATA_O == 32'h0)
		else $error("misaligned read not zero");
	a_one_low: assert property (age == 3'h7 && ctl[0] == 1'b0 && ctl[2] == 1'b0 && ctl[26] == 1'b0 && ctl[30] == 1'b0 |-> !CHAN_ONE_PAD_O && !CHAN_ONE_PAD_OE_N_O)
		else $error("channel one not held low");
	a_two_low: assert property (age == 3'h7 && ctl[1] == 1'b0 && ctl[3] == 1'b0 && ctl[27] == 1'b0 && ctl[31] == 1'b0 |-> !CHAN_TWO_PAD_O && !CHAN_TWO_PAD_OE_N_O)
		else $error("channel two not held low");
	a_one_hiz: assert property (age == 3'h7 && ctl[30] |-> CHAN_ONE_PAD_O)
		else $error("pad data differs from hiz bit");
	a_clk_stop: assert property (age == 3'h7 && ctl[0] && !ctl[15] && !ctl[30] |=> $stable(CHAN_ONE_PAD_O))
		else $error("pad moved with clock off");
endmodule : dpwm_top_chk
bind dpwm_top dpwm_top_chk chk (.*);

/* File: dv/tb.sv */
`timescale 1ns/100ps
module tb;
	logic        CORE_CLK_I = 1'b0;
	logic        RST_I = 1'b1;
	logic        CRYSTAL_TICK_I = 1'b0;
	logic        MAIN_PERIPHERAL_CLOCK_TICK_I = 1'b0;
	logic        FIXED_PLL_THIRD_TICK_I = 1'b0;
	logic        FIXED_PLL_QUARTER_TICK_I = 1'b0;
	logic [4:0]  ADDR_I = 5'h0;
	logic [31:0] WDATA_I = 32'h0;
	logic        WR_I = 1'b0;
	logic        RD_I = 1'b0;
	logic [31:0] RDATA_O;
	logic        CHAN_ONE_PAD_O;
	logic        CHAN_ONE_PAD_OE_N_O;
	logic        CHAN_TWO_PAD_O;
	logic        CHAN_TWO_PAD_OE_N_O;
	logic        two_line;
	logic [31:0] h1, h2, n1, v, d;
	int          failures = 0;
	int          samples_checked = 0;
	int          tk = 0;
	int          p[4] = '{2, 3, 5, 7};
	dpwm_top uut (.*);
	dpwm_pad_model pad_two (.clk_i(CORE_CLK_I), .pad_i(CHAN_TWO_PAD_O),
		.pad_oe_n_i(CHAN_TWO_PAD_OE_N_O), .line_o(two_line));
	always #25 CORE_CLK_I = ~CORE_CLK_I;
	// Source ticks have coprime periods so a wrong select shows as a wrong duty count.
	always @(posedge CORE_CLK_I) begin
		tk <= tk + 1;
		CRYSTAL_TICK_I <= (tk % 2 == 0);
		MAIN_PERIPHERAL_CLOCK_TICK_I <= (tk % 3 == 0);
		FIXED_PLL_THIRD_TICK_I <= (tk % 5 == 0);
		FIXED_PLL_QUARTER_TICK_I <= (tk % 7 == 0);
	end
	task automatic wr(input logic [4:0] a, input logic [31:0] x);
		WR_I <= 1'b1;
		ADDR_I <= a;
		WDATA_I <= x;
		@(posedge CORE_CLK_I);
		WR_I <= 1'b0;
	endtask : wr
	task automatic cfg(input logic [4:0] a, input logic [31:0] x);
		wr(a, x);
		@(posedge CORE_CLK_I);
	endtask : cfg
	task automatic rd(input logic [4:0] a, output logic [31:0] x);
		RD_I <= 1'b1;
		ADDR_I <= a;
		@(posedge CORE_CLK_I);
		RD_I <= 1'b0;
		#1;
		x = RDATA_O;
		@(posedge CORE_CLK_I);
	endtask : rd
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : cmp
	// Windows span whole periods, so the counts do not depend on phase.
	task automatic run(input logic [31:0] c, input int w, input int e1, input int e2, input int e3);
		cfg(5'h08, c);
		repeat (w) @(posedge CORE_CLK_I);
		h1 = 0;
		h2 = 0;
		n1 = 0;
		repeat (w) begin
			@(posedge CORE_CLK_I);
			#1;
			h1 = h1 + 32'(CHAN_ONE_PAD_O);
			h2 = h2 + 32'(two_line);
			n1 = n1 + 32'(!CHAN_ONE_PAD_OE_N_O);
		end
		cmp("one high", 32'(e1), h1);
		cmp("two high", 32'(e2), h2);
		cmp("one drive", 32'(e3), n1);
	endtask : run
	task automatic end_of_test;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (16) @(posedge CORE_CLK_I);
		RST_I <= 1'b0;
		@(posedge CORE_CLK_I);
		for (int i = 0; i < 8; i++) begin
			rd(5'(i * 4), v);
			cmp("reset", 32'h0, v);
		end
		for (int i = 0; i < 8; i++) begin
			d = 32'hfedc_ba98 ^ 32'(i * 3);
			wr(5'(i * 4), d);
			rd(5'(i * 4), v);
			cmp("readback", (i == 7) ? (d & 32'h0000_03ff) : d, v);
		end
		rd(5'h09, v);
		cmp("misaligned", 32'h0, v);
		cfg(5'h1c, 32'h0);
		cfg(5'h10, 32'h0);
		cfg(5'h00, 32'h0003_0005);
		cfg(5'h04, 32'h0002_0006);
		for (int s = 0; s < 4; s++)
			run(32'h0881_8103 | 32'(s) << 4 | 32'(s) << 6, 32 * p[s], 12 * p[s], 24 * p[s], 32 * p[s]);
		cfg(5'h08, 32'h0);
		run(32'hc000_8001, 32, 32, 32, 12);
		cfg(5'h00, 32'h0000_0004);
		run(32'h1000_8001, 32, 0, 0, 32);
		cfg(5'h00, 32'h0004_0000);
		run(32'h1000_8001, 32, 32, 0, 32);
		cfg(5'h00, 32'h0003_0005);
		cfg(5'h14, 32'h0001_0007);
		run(32'h0200_8001, 64, 16, 0, 64);
		cfg(5'h08, 32'h0);
		cfg(5'h1c, 32'h0000_0100);
		run(32'h0000_8001, 64, 12, 0, 64);
		cfg(5'h1c, 32'h0);
		cfg(5'h0c, 32'hc000_4000);
		run(32'h0080_800c, 64, 16, 48, 64);
		cfg(5'h08, 32'h0000_0001);
		repeat (16) @(posedge CORE_CLK_I);
		end_of_test();
	end
	initial begin
		#(50 * 20000);
		failures++;
		end_of_test();
	end
endmodule : tb

/* File: hw/dpwm_pkg.sv */
package dpwm_pkg;

	localparam logic [2:0] REG_CHAN_ONE_DUTY        = 3'h0;
	localparam logic [2:0] REG_CHAN_TWO_DUTY        = 3'h1;
	localparam logic [2:0] REG_GENERATOR_CONTROL    = 3'h2;
	localparam logic [2:0] REG_DELTA_SIGMA_VALUES   = 3'h3;
	localparam logic [2:0] REG_ALTERNATE_TIMERS     = 3'h4;
	localparam logic [2:0] REG_CHAN_ONE_SECOND_DUTY = 3'h5;
	localparam logic [2:0] REG_CHAN_TWO_SECOND_DUTY = 3'h6;
	localparam logic [2:0] REG_BLINK_CONTROL        = 3'h7;

	localparam int ADDR_W = 5;

	localparam int HIGH_LSB = 16;
	localparam int LOW_LSB  = 0;

	localparam int HIZ_LSB      = 30;
	localparam int CONST_LSB    = 28;
	localparam int INV_LSB      = 26;
	localparam int PAIR2_ONE    = 25;
	localparam int PAIR2_TWO    = 24;
	localparam int CLKEN_TWO    = 23;
	localparam int DIV_TWO_LSB  = 16;
	localparam int CLKEN_ONE    = 15;
	localparam int DIV_ONE_LSB  = 8;
	localparam int SEL_TWO_LSB  = 6;
	localparam int SEL_ONE_LSB  = 4;
	localparam int SIGMA_ON_LSB = 2;
	localparam int PWM_ON_LSB   = 0;

	localparam int SIGMA_TWO_LSB = 16;
	localparam int SIGMA_ONE_LSB = 0;

	localparam int REPEAT_ONE_PRI = 24;
	localparam int REPEAT_ONE_ALT = 16;
	localparam int REPEAT_TWO_PRI = 8;
	localparam int REPEAT_TWO_ALT = 0;

	localparam int BLINK_ON_LSB  = 8;
	localparam int BLINK_CNT_LSB = 0;
	localparam logic [31:0] BLINK_MASK = 32'h0000_03ff;

	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		SRC_CRYSTAL     = 2'b00,
		SRC_MAIN_PERIPH = 2'b01,
		SRC_PLL_THIRD   = 2'b10,
		SRC_PLL_QUARTER = 2'b11
	} dpwm_src_e;

endpackage : dpwm_pkg

/* File: hw/dpwm_top.sv */
// Notes on behaviour
// RULE1 - Two independent channels, each configurable as pulse-width or delta-sigma output.
// RULE2 - Primary duty register upper field holds the high-phase count.
// RULE3 - Primary duty register lower 16 bits hold the low-phase count.
// RULE4 - Second duty register per channel gives alternate high and low counts.
// RULE5 - High-impedance bit: waveform drives pad enable, pad data equals the bit.
// RULE6 - Constant bit allows steady 0% or 100% duty output.
// RULE7 - Invert bit inverts the channel waveform before it leaves.
// RULE8 - Per-channel clock enable; channel counting runs only while it is one.
// RULE9 - Channel clock is the selected source divided by divider field plus one.
// RULE10 - Each channel selects its source clock through a 2-bit field.
// RULE11 - Pulse-width enable set gives pulse-width waveform; otherwise sigma enable decides.
// RULE12 - Sigma enable gives delta-sigma stream; both clear hold the output low.
// RULE13 - Sigma register: channel one lower field, channel two upper field, sets density.
// RULE14 - Blink enable bits: channel two at bit 9, channel one at bit 8.
// RULE15 - Blink count nibbles: channel two upper, channel one lower.
// RULE16 - Blink register bits 31 to 10 are reserved and read as zero.
// RULE17 - Clock select picks crystal, main peripheral, PLL third or PLL quarter.
// RULE18 - Pulse-width mode drives high for high count, low for low count, repeating.
// RULE19 - Second-pair enable alternates primary and second pairs using repeat counts.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps

module dpwm_chan (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [3:0]  src_tick_i,
	input  wire logic [1:0]  src_sel_i,
	input  wire logic        clk_on_i,
	input  wire logic [6:0]  div_i,
	input  wire logic [31:0] duty_i,
	input  wire logic [31:0] duty2_i,
	input  wire logic        pair2_on_i,
	input  wire logic [7:0]  rep_pri_i,
	input  wire logic [7:0]  rep_alt_i,
	input  wire logic        pwm_on_i,
	input  wire logic        sigma_on_i,
	input  wire logic [15:0] sigma_level_i,
	input  wire logic        const_on_i,
	input  wire logic        inv_i,
	input  wire logic        hiz_i,
	input  wire logic        blink_on_i,
	input  wire logic [3:0]  blink_cnt_i,
	output logic             pad_o,
	output logic             pad_oe_n_o
);
	logic        tick;
	logic [6:0]  div_reg;
	logic [15:0] cnt_reg;
	logic        phase_reg;
	logic        alt_reg;
	logic [7:0]  rep_reg;
	logic [16:0] acc_reg;
	logic        sigma_bit_reg;
	logic [3:0]  blink_reg;
	logic        blink_gate_reg;
	logic [15:0] high_cnt;
	logic [15:0] low_cnt;
	logic        wave;
	logic        src_tick;

	// A divided tick is used rather than a gated clock so the whole block stays on one clock.
	assign src_tick = src_tick_i[src_sel_i]; // RULE10 RULE17

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_reg <= 7'h00;
		end else if (!clk_on_i) begin // RULE8
			div_reg <= 7'h00;
		end else if (src_tick) begin
			div_reg <= (div_reg >= div_i) ? 7'h00 : div_reg + 7'h01; // RULE9
		end
	end

	assign tick = clk_on_i && src_tick && (div_reg >= div_i); // RULE8 RULE9

	// The upper field nominally spans 31..15; bit 15 belongs to the low count, so high uses 31..16.
	// A channel whose second pair is switched off always uses the primary pair.
	assign high_cnt = (alt_reg && pair2_on_i) ? duty2_i[31:16] : duty_i[31:16]; // RULE2 RULE4
	assign low_cnt  = (alt_reg && pair2_on_i) ? duty2_i[15:0] : duty_i[15:0]; // RULE3 RULE4

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg   <= 16'h0000;
			phase_reg <= 1'b1;
			alt_reg   <= 1'b0;
			rep_reg   <= 8'h00;
		end else if (!pwm_on_i) begin
			cnt_reg   <= 16'h0000;
			phase_reg <= 1'b1;
			alt_reg   <= 1'b0;
			rep_reg   <= 8'h00;
		end else if (tick) begin
			if (phase_reg && cnt_reg + 16'h0001 >= high_cnt) begin // RULE18
				cnt_reg   <= 16'h0000;
				phase_reg <= 1'b0;
			end else if (!phase_reg && cnt_reg + 16'h0001 >= low_cnt) begin // RULE18
				cnt_reg   <= 16'h0000;
				phase_reg <= 1'b1;
				if (pair2_on_i && rep_reg >= (alt_reg ? rep_alt_i : rep_pri_i)) begin // RULE19
					alt_reg <= !alt_reg;
					rep_reg <= 8'h00;
				end else begin
					rep_reg <= rep_reg + 8'h01;
				end
			end else begin
				cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			acc_reg       <= 17'h00000;
			sigma_bit_reg <= 1'b0;
		end else if (tick) begin
			acc_reg       <= {1'b0, acc_reg[15:0]} + {1'b0, sigma_level_i}; // RULE13
			sigma_bit_reg <= acc_reg[16];
		end
	end

	// Blink counts completed pulse-width periods and toggles the output gate off or back on each time the count is reached.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			blink_reg      <= 4'h0;
			blink_gate_reg <= 1'b1;
		end else if (!blink_on_i) begin
			blink_reg      <= 4'h0;
			blink_gate_reg <= 1'b1;
		end else if (tick && pwm_on_i && !phase_reg && cnt_reg + 16'h0001 >= low_cnt) begin
			if (blink_reg >= blink_cnt_i) begin // RULE14 RULE15
				blink_reg      <= 4'h0;
				blink_gate_reg <= !blink_gate_reg;
			end else begin
				blink_reg <= blink_reg + 4'h1;
			end
		end
	end

	always_comb begin
		if (pwm_on_i) begin // RULE11
			if (const_on_i && high_cnt == 16'h0000) begin // RULE6
				wave = 1'b0;
			end else if (const_on_i && low_cnt == 16'h0000) begin // RULE6
				wave = 1'b1;
			end else begin
				wave = phase_reg && blink_gate_reg;
			end
		end else if (sigma_on_i) begin // RULE12
			wave = sigma_bit_reg;
		end else begin
			wave = 1'b0; // RULE12
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pad_o      <= 1'b0;
			pad_oe_n_o <= 1'b0;
		end else if (hiz_i) begin
			pad_o      <= 1'b1; // RULE5
			pad_oe_n_o <= !(wave ^ inv_i); // RULE5 RULE7
		end else begin
			pad_o      <= wave ^ inv_i; // RULE7
			pad_oe_n_o <= 1'b0;
		end
	end
endmodule : dpwm_chan

module dpwm_top (
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_I,
	input  wire logic        CRYSTAL_TICK_I,
	input  wire logic        MAIN_PERIPHERAL_CLOCK_TICK_I,
	input  wire logic        FIXED_PLL_THIRD_TICK_I,
	input  wire logic        FIXED_PLL_QUARTER_TICK_I,
	input  wire logic [4:0]  ADDR_I,
	input  wire logic [31:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [31:0] RDATA_O,
	output logic             CHAN_ONE_PAD_O,
	output logic             CHAN_ONE_PAD_OE_N_O,
	output logic             CHAN_TWO_PAD_O,
	output logic             CHAN_TWO_PAD_OE_N_O
);
	logic [31:0] regs [0:7];
	logic [3:0]  ticks;
	logic [2:0]  idx;
	logic        hit;

	// Byte address is four times the register index.
	assign idx   = ADDR_I[4:2];
	assign hit   = (ADDR_I[1:0] == 2'b00);
	assign ticks = {FIXED_PLL_QUARTER_TICK_I, FIXED_PLL_THIRD_TICK_I,
		MAIN_PERIPHERAL_CLOCK_TICK_I, CRYSTAL_TICK_I};

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			for (int i = 0; i < 8; i++) begin
				regs[i] <= dpwm_pkg::REG_RESET;
			end
		end else if (WR_I && hit) begin
			if (idx == dpwm_pkg::REG_BLINK_CONTROL) begin
				regs[idx] <= WDATA_I & dpwm_pkg::BLINK_MASK; // RULE16
			end else begin
				regs[idx] <= WDATA_I;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			RDATA_O <= 32'h0000_0000;
		end else if (RD_I && hit) begin
			RDATA_O <= regs[idx];
		end else begin
			RDATA_O <= 32'h0000_0000;
		end
	end

	// Channel one uses the lower bit of each pair, channel two the upper, except second-pair enable: bit 25 for one, bit 24 for two.
	for (genvar c = 0; c < 2; c++) begin : g_chan // RULE1
		logic [31:0] ctl;
		logic [31:0] blk;
		logic        pad;
		logic        pad_oe_n;
		assign ctl = regs[dpwm_pkg::REG_GENERATOR_CONTROL];
		assign blk = regs[dpwm_pkg::REG_BLINK_CONTROL];
		dpwm_chan u_chan (
			.clk_i        (CORE_CLK_I),
			.rst_i        (RST_I),
			.src_tick_i   (ticks),
			.src_sel_i    (c == 0 ? ctl[dpwm_pkg::SEL_ONE_LSB +: 2] : ctl[dpwm_pkg::SEL_TWO_LSB +: 2]),
			.clk_on_i     (c == 0 ? ctl[dpwm_pkg::CLKEN_ONE] : ctl[dpwm_pkg::CLKEN_TWO]),
			.div_i        (c == 0 ? ctl[dpwm_pkg::DIV_ONE_LSB +: 7] : ctl[dpwm_pkg::DIV_TWO_LSB +: 7]),
			.duty_i       (regs[dpwm_pkg::REG_CHAN_ONE_DUTY + 3'(c)]),
			.duty2_i      (regs[dpwm_pkg::REG_CHAN_ONE_SECOND_DUTY + 3'(c)]),
			.pair2_on_i   (c == 0 ? ctl[dpwm_pkg::PAIR2_ONE] : ctl[dpwm_pkg::PAIR2_TWO]),
			.rep_pri_i    (c == 0 ? regs[4][dpwm_pkg::REPEAT_ONE_PRI +: 8]
				: regs[4][dpwm_pkg::REPEAT_TWO_PRI +: 8]),
			.rep_alt_i    (c == 0 ? regs[4][dpwm_pkg::REPEAT_ONE_ALT +: 8]
				: regs[4][dpwm_pkg::REPEAT_TWO_ALT +: 8]),
			.pwm_on_i     (ctl[dpwm_pkg::PWM_ON_LSB + c]),
			.sigma_on_i   (ctl[dpwm_pkg::SIGMA_ON_LSB + c]),
			.sigma_level_i(c == 0 ? regs[3][dpwm_pkg::SIGMA_ONE_LSB +: 16]
				: regs[3][dpwm_pkg::SIGMA_TWO_LSB +: 16]),
			.const_on_i   (ctl[dpwm_pkg::CONST_LSB + c]),
			.inv_i        (ctl[dpwm_pkg::INV_LSB + c]),
			.hiz_i        (ctl[dpwm_pkg::HIZ_LSB + c]),
			.blink_on_i   (blk[dpwm_pkg::BLINK_ON_LSB + c]),
			.blink_cnt_i  (blk[dpwm_pkg::BLINK_CNT_LSB + 4 * c +: 4]),
			.pad_o        (pad),
			.pad_oe_n_o   (pad_oe_n)
		);
	end

	assign CHAN_ONE_PAD_O      = g_chan[0].pad;
	assign CHAN_ONE_PAD_OE_N_O = g_chan[0].pad_oe_n;
	assign CHAN_TWO_PAD_O      = g_chan[1].pad;
	assign CHAN_TWO_PAD_OE_N_O = g_chan[1].pad_oe_n;
endmodule : dpwm_top
